// >>> vector_fp_multiply_add_units_tb_top.sv
// self-checking bench of the vector multiply and add unit
`default_nettype none
module vector_fp_multiply_add_units_tb_top;
  import vfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam fp_word_type ONE_W = {1'b0, 15'h4001, 48'h800000000000};
  localparam fp_word_type TWO_W = {1'b0, 15'h4002, 48'h800000000000};
  logic clk_i, sys_rst_i, issue_valid_i, issue_ready_o, done_o;
  instr_type issue_instr_i;
  fp_word_type scalar_src_i, first_vector_src_i, second_vector_src_i;
  fp_word_type exp_word;
  logic [6:0] vector_length_count_i;
  rd_req_type vrf_rd_o;
  wr_req_type vrf_wr_o;
  int bad_count, cmp_count, wcnt, dcnt;
  vfp_unit u_dut(.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .issue_valid_i(issue_valid_i), .issue_instr_i(issue_instr_i),
    .scalar_src_i(scalar_src_i),
    .vector_length_count_i(vector_length_count_i),
    .first_vector_src_i(first_vector_src_i),
    .second_vector_src_i(second_vector_src_i),
    .issue_ready_o(issue_ready_o), .done_o(done_o),
    .vrf_rd_o(vrf_rd_o), .vrf_wr_o(vrf_wr_o));
  vfp_vrf_model u_vrf(.clk_i(clk_i), .rd_i(vrf_rd_o), .wr_i(vrf_wr_o),
    .first_o(first_vector_src_i), .second_o(second_vector_src_i));
  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // issue one instruction into dest 5, wait done, check count and timing
  task automatic run(input logic [6:0] opc, input logic [2:0] j,
    input logic [2:0] k, input logic [6:0] vl, input fp_word_type exp);
    int n;
    exp_word = exp;
    wcnt = 0;
    n = 0;
    issue_valid_i = 1'b1;
    issue_instr_i = {opc, 3'h5, j, k};
    vector_length_count_i = vl;
    @(negedge clk_i);
    issue_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(64'(n), 64'(4 * vl));
    chk(64'(wcnt), 64'(vl));
    @(negedge clk_i);
  endtask
  // unknown opcode: no completion, unit stays ready
  task automatic refuse();
    dcnt = 0;
    issue_valid_i = 1'b1;
    issue_instr_i = {7'h7C, 3'h5, 3'h2, 3'h3};
    @(negedge clk_i);
    issue_valid_i = 1'b0;
    repeat (8) @(negedge clk_i);
    chk(64'(dcnt), 64'h0);
    chk({63'h0, issue_ready_o}, 64'h1);
  endtask
  // watch writes and completions
  always @(negedge clk_i)
  begin
    if (done_o === 1'b1)
      dcnt++;
    if (vrf_wr_o.en === 1'b1)
    begin
      chk(64'(vrf_wr_o.elem), 64'(wcnt));
      chk(64'(vrf_wr_o.dst), 64'h5);
      chk(vrf_wr_o.data, exp_word);
      wcnt++;
    end
  end
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    #(25 * 5000);
    bad_count++;
    results();
  end
  initial
  begin
    sys_rst_i = 1'b1;
    issue_valid_i = 1'b0;
    issue_instr_i = '0;
    vector_length_count_i = 7'h00;
    scalar_src_i = ONE_W;
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    // every opcode on ones: products and two-minus give one
    for (int o = 0; o < 12; o++)
      run(7'h70 + 7'(o), 3'h2, 3'h3, 7'h03, (o < 8) ? ONE_W :
        ((o < 10) ? TWO_W : 64'h0));
    run(7'h78, 3'h0, 3'h7, 7'h01, {1'b0, 15'h4000,
      48'h800000000000});
    run(7'h7A, 3'h0, 3'h7, 7'h02, {1'b1, 15'h4000,
      48'h800000000000});
    run(7'h71, 3'h2, 3'h7, 7'h01, {1'b0, 15'h4002,
      48'h200000000000});
    run(7'h7B, 3'h2, 3'h3, 7'h00, 64'h0);
    run(7'h79, 3'h2, 3'h3, 7'h40, TWO_W);
    // scalar with a low coefficient bit: half precision must clear it
    scalar_src_i = {1'b0, 15'h4001, 48'h800000000001};
    run(7'h72, 3'h2, 3'h3, 7'h02, ONE_W);
    scalar_src_i = ONE_W;
    refuse();
    results();
  end
endmodule
`default_nettype wire

// >>> vfp_add_core.sv
// floating-point add/subtract core with optional post-normalization
`default_nettype none
module vfp_add_core
  import vfp_pkg::*;
(
  input wire vfp_pkg::fp_word_type x_i,
  input wire vfp_pkg::fp_word_type y_i,
  input wire logic sub_i,
  input wire logic norm_i,
  output vfp_pkg::fp_word_type sum_o
);
  `include "vfp_cfg.svh"

  fp_word_type y_eff;
  fp_word_type big;
  fp_word_type sml;
  fp_word_type res;
  logic [14:0] diff;
  logic [47:0] aligned;
  logic [48:0] mag;
  logic sgn;
  logic [15:0] ex;
  logic [5:0] lz;
  logic found;

  // align, add magnitudes, then correct carry or normalize
  always_comb
  begin
    y_eff = y_i;
    y_eff.sign = y_i.sign ^ sub_i;
    if (x_i.exp >= y_eff.exp)
    begin
      big = x_i;
      sml = y_eff;
    end
    else
    begin
      big = y_eff;
      sml = x_i;
    end
    diff = big.exp - sml.exp;
    aligned = (diff > 15'h002F) ? 48'h000000000000 : (sml.coef >> diff);
    if (big.sign == sml.sign)
    begin
      mag = {1'b0, big.coef} + {1'b0, aligned};
      sgn = big.sign;
    end
    else if (big.coef >= aligned)
    begin
      mag = {1'b0, big.coef - aligned};
      sgn = big.sign;
    end
    else
    begin
      mag = {1'b0, aligned - big.coef};
      sgn = sml.sign;
    end
    ex = {1'b0, big.exp};
    lz = 6'h00;
    found = 1'b0;
    for (int n = `VFP_COEF_MSB; n >= 0; n--)
    begin
      if (!found)
      begin
        if (mag[n])
          found = 1'b1;
        else
          lz = lz + 6'h01;
      end
    end
    if (mag[48])
    begin
      mag = mag >> 1; // carry out of the coefficient
      ex = ex + 16'h0001;
    end
    else if (norm_i)
    begin
      mag = mag << lz; // shift leading one to the top
      ex = ex - {10'h000, lz};
    end
    res.sign = sgn;
    res.exp = ex[14:0];
    res.coef = mag[47:0];
    if (mag == 49'h0)
      res = '0; // exact zero is all zeros
  end

  assign sum_o = res;

endmodule
`default_nettype wire

// >>> vfp_cfg.svh
// constants of the vector floating-point multiply and add unit
`ifndef VFP_CFG_SVH
`define VFP_CFG_SVH

// exponent bias and the constant two used by the two-minus forms
`define VFP_EXP_BIAS 15'h4000
`define VFP_TWO_EXP 15'h4002
`define VFP_TWO_COEF 48'h800000000000

// opcodes (octal 160..167 multiply, 170..173 add)
`define VFP_OPC_MUL_SF 7'h70
`define VFP_OPC_MUL_VF 7'h71
`define VFP_OPC_MUL_SH 7'h72
`define VFP_OPC_MUL_VH 7'h73
`define VFP_OPC_MUL_SR 7'h74
`define VFP_OPC_MUL_VR 7'h75
`define VFP_OPC_MUL_SI 7'h76
`define VFP_OPC_MUL_VI 7'h77
`define VFP_OPC_ADD_SF 7'h78
`define VFP_OPC_ADD_VF 7'h79
`define VFP_OPC_SUB_SF 7'h7A
`define VFP_OPC_SUB_VF 7'h7B

// rounding positions in the 97-bit product and the half-precision clear
`define VFP_RND_FULL_POS 47
`define VFP_RND_HALF_POS 65
`define VFP_HALF_ZERO_MSB 17

// coefficient width, top bit of the coefficient and largest element count
`define VFP_COEF_W 48
`define VFP_COEF_MSB 47
`define VFP_MAX_VL 7'h40

// reset values
`define VFP_ELEM_RST 6'h00
`define VFP_VL_RST 7'h00

`endif

// >>> vfp_pkg.sv
// types of the vector floating-point multiply and add unit
`default_nettype none
package vfp_pkg;

  // instruction word: 7-bit opcode then octal i, j, k designators
  typedef struct packed {
    logic [6:0] opc;
    logic [2:0] dst;
    logic [2:0] src_a;
    logic [2:0] src_b;
  } instr_type;

  // floating-point word: sign, biased exponent, coefficient
  typedef struct packed {
    logic sign;
    logic [14:0] exp;
    logic [47:0] coef;
  } fp_word_type;

  // element read request to the vector register file
  typedef struct packed {
    logic en;
    logic [2:0] reg_a;
    logic [2:0] reg_b;
    logic [5:0] elem;
  } rd_req_type;

  // element write request to the vector register file
  typedef struct packed {
    logic en;
    logic [2:0] dst;
    logic [5:0] elem;
    fp_word_type data;
  } wr_req_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_READ = 3'b001,
    PH_CAPT = 3'b010,
    PH_CALC = 3'b011,
    PH_WRITE = 3'b100
  } phase_type;

  // whole state of the sequencer
  typedef struct packed {
    phase_type phase;
    instr_type instr;
    fp_word_type scalar;
    logic [6:0] vl;
    logic [5:0] elem;
    fp_word_type a;
    fp_word_type b;
    rd_req_type rd;
    wr_req_type wr;
    logic ready;
    logic done;
  } unit_state_type;

endpackage
`default_nettype wire

// >>> vfp_unit.sv
// vector floating-point multiply and add unit with element sequencer
// Summary of operation
// - 165: rounded products of first and second vector elements.
// - 166: two minus product of scalar and second vector element.
// - 167: two minus product of the two vector elements.
// - Multiply results stay unnormalized if either input is unnormalized.
// - Exactly vector_length_count element operations are performed, at most 64 (larger counts are clamped).
// - Opcodes 160 to 167 run in the multiply datapath.
// - 170: scalar plus each second vector element.
// - 170 with j zero: normalize each second vector element.
// - 171: sums of corresponding vector elements.
// - 172: scalar minus each second vector element.
// - 172 with j zero: normalized negative of each element.
// - 173: first vector element minus second vector element.
// - Add-unit results are normalized, except for 166 and 167 when either input is unnormalized.
// - Opcodes 170 to 173 run in the add datapath.
// - 160 and 161: plain products, scalar or vector first operand.
// - 162 and 163: half-precision rounding, low 18 bits cleared.
// - 164: rounded products of scalar and second vector element.
// - Elements at or beyond the length count are never written.
`default_nettype none
module vfp_unit
  import vfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic issue_valid_i,
  input wire vfp_pkg::instr_type issue_instr_i,
  input wire vfp_pkg::fp_word_type scalar_src_i,
  input wire logic [6:0] vector_length_count_i,
  input wire vfp_pkg::fp_word_type first_vector_src_i,
  input wire vfp_pkg::fp_word_type second_vector_src_i,
  output logic issue_ready_o,
  output logic done_o,
  output vfp_pkg::rd_req_type vrf_rd_o,
  output vfp_pkg::wr_req_type vrf_wr_o
);
  `include "vfp_cfg.svh"

  unit_state_type st_r;
  unit_state_type st_nxt;

  logic mul_grp;
  logic add_grp;
  logic two_minus;
  logic rnd_full;
  logic rnd_half;
  logic both_norm;
  logic op_known;
  logic [6:0] vl_clamped;
  fp_word_type op_x;
  fp_word_type prod;
  fp_word_type add_x;
  fp_word_type add_y;
  fp_word_type add_sum;
  fp_word_type result;
  logic add_sub;
  logic add_norm;

  // coefficient product with optional post-normalize and rounding
  function automatic fp_word_type fp_mul(
    input fp_word_type a,
    input fp_word_type b,
    input logic rnd,
    input logic half
  );
    logic [95:0] p;
    logic [96:0] r;
    logic [16:0] e;
    fp_word_type res;
    p = a.coef * b.coef;
    e = {2'b00, a.exp} + {2'b00, b.exp} - {2'b00, `VFP_EXP_BIAS};
    // post-normalize only when both inputs are normalized
    if (a.coef[`VFP_COEF_MSB] && b.coef[`VFP_COEF_MSB] && !p[95])
    begin
      p = p << 1;
      e = e - 17'h00001;
    end
    r = {1'b0, p};
    if (half)
      r = r + (97'h1 << `VFP_RND_HALF_POS);
    else if (rnd)
      r = r + (97'h1 << `VFP_RND_FULL_POS);
    if (r[96])
    begin
      r = r >> 1; // rounding carried out of the coefficient
      e = e + 17'h00001;
    end
    res.sign = a.sign ^ b.sign;
    res.exp = e[14:0];
    res.coef = r[95:48];
    if (half)
      res.coef[`VFP_HALF_ZERO_MSB:0] = '0;
    if ((a.coef == 48'h0) || (b.coef == 48'h0))
      res = '0;
    return res;
  endfunction

  // opcode decode of the held instruction
  always_comb
  begin
    mul_grp = (st_r.instr.opc >= `VFP_OPC_MUL_SF) &&
              (st_r.instr.opc <= `VFP_OPC_MUL_VI);
    add_grp = (st_r.instr.opc >= `VFP_OPC_ADD_SF) &&
              (st_r.instr.opc <= `VFP_OPC_SUB_VF);
    rnd_half = mul_grp && ((st_r.instr.opc == `VFP_OPC_MUL_SH) ||
               (st_r.instr.opc == `VFP_OPC_MUL_VH));
    rnd_full = mul_grp && ((st_r.instr.opc == `VFP_OPC_MUL_SR) ||
               (st_r.instr.opc == `VFP_OPC_MUL_VR) ||
               (st_r.instr.opc == `VFP_OPC_MUL_SI) ||
               (st_r.instr.opc == `VFP_OPC_MUL_VI));
    two_minus = (st_r.instr.opc == `VFP_OPC_MUL_SI) ||
                (st_r.instr.opc == `VFP_OPC_MUL_VI);
    add_sub = (st_r.instr.opc == `VFP_OPC_SUB_SF) ||
              (st_r.instr.opc == `VFP_OPC_SUB_VF);
  end

  // first operand: odd opcodes take the vector, even ones the scalar, even add opcodes with j zero take zero
  always_comb
  begin
    if (st_r.instr.opc[0])
      op_x = st_r.a;
    else if (add_grp && (st_r.instr.src_a == 3'h0))
      op_x = '0;
    else
      op_x = st_r.scalar;
  end

  // multiply path feeding the shared adder
  always_comb
  begin
    prod = fp_mul(op_x, st_r.b, rnd_full, rnd_half);
    both_norm = op_x.coef[`VFP_COEF_MSB] && st_r.b.coef[`VFP_COEF_MSB];
    if (two_minus)
    begin
      add_x.sign = 1'b0;
      add_x.exp = `VFP_TWO_EXP;
      add_x.coef = `VFP_TWO_COEF;
      add_y = prod;
      add_norm = both_norm;
    end
    else
    begin
      add_x = op_x;
      add_y = st_r.b;
      add_norm = 1'b1;
    end
  end

  vfp_add_core u_add (
    .x_i(add_x),
    .y_i(add_y),
    .sub_i(add_sub || two_minus),
    .norm_i(add_norm),
    .sum_o(add_sum)
  );

  // pick the element result of the active datapath
  always_comb
  begin
    if (mul_grp && !two_minus)
      result = prod;
    else
      result = add_sum;
  end

  // accepted opcodes and clamped length
  always_comb
  begin
    op_known = (issue_instr_i.opc >= `VFP_OPC_MUL_SF) &&
               (issue_instr_i.opc <= `VFP_OPC_SUB_VF);
    if (vector_length_count_i > `VFP_MAX_VL)
      vl_clamped = `VFP_MAX_VL;
    else
      vl_clamped = vector_length_count_i;
  end

  // element sequencer
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.rd.en = 1'b0;
    st_nxt.wr.en = 1'b0;
    case (st_r.phase)
      PH_IDLE:
      begin
        st_nxt.ready = 1'b1;
        if (issue_valid_i && op_known && st_r.ready)
        begin
          st_nxt.instr = issue_instr_i;
          st_nxt.scalar = scalar_src_i;
          st_nxt.vl = vl_clamped;
          st_nxt.elem = `VFP_ELEM_RST;
          if (vl_clamped == 7'h00)
          begin
            st_nxt.done = 1'b1;
          end
          else
          begin
            st_nxt.ready = 1'b0;
            st_nxt.phase = PH_READ;
            st_nxt.rd.en = 1'b1;
            st_nxt.rd.reg_a = issue_instr_i.src_a;
            st_nxt.rd.reg_b = issue_instr_i.src_b;
            st_nxt.rd.elem = `VFP_ELEM_RST;
          end
        end
      end
      PH_READ:
        st_nxt.phase = PH_CAPT; // file answers one cycle after request
      PH_CAPT:
      begin
        st_nxt.a = first_vector_src_i;
        st_nxt.b = second_vector_src_i;
        st_nxt.phase = PH_CALC;
      end
      PH_CALC:
      begin
        st_nxt.wr.en = 1'b1;
        st_nxt.wr.dst = st_r.instr.dst;
        st_nxt.wr.elem = st_r.elem;
        st_nxt.wr.data = result;
        st_nxt.phase = PH_WRITE;
      end
      PH_WRITE:
      begin
        if (({1'b0, st_r.elem} + 7'h01) < st_r.vl)
        begin
          st_nxt.elem = st_r.elem + 6'h01;
          st_nxt.rd.en = 1'b1;
          st_nxt.rd.elem = st_r.elem + 6'h01;
          st_nxt.phase = PH_READ;
        end
        else
        begin
          st_nxt.done = 1'b1;
          st_nxt.ready = 1'b1;
          st_nxt.phase = PH_IDLE;
        end
      end
      default:
      begin
        st_nxt.phase = PH_IDLE;
        st_nxt.ready = 1'b1;
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
      st_r.phase <= PH_IDLE;
      st_r.vl <= `VFP_VL_RST;
      st_r.elem <= `VFP_ELEM_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign issue_ready_o = st_r.ready;
  assign done_o = st_r.done;
  assign vrf_rd_o = st_r.rd;
  assign vrf_wr_o = st_r.wr;

endmodule
`default_nettype wire

// >>> vfp_unit_sva.sv
// checker for the vector multiply and add unit ports
`default_nettype none
module vfp_unit_chk
  import vfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic issue_valid_i,
  input wire vfp_pkg::instr_type issue_instr_i,
  input wire logic [6:0] vector_length_count_i,
  input wire logic issue_ready_o,
  input wire logic done_o,
  input wire vfp_pkg::rd_req_type vrf_rd_o,
  input wire vfp_pkg::wr_req_type vrf_wr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic take;
  logic bad_opc;
  // accepted instruction and out-of-range opcode
  assign take = issue_ready_o && issue_valid_i &&
    issue_instr_i.opc >= 7'h70 && issue_instr_i.opc <= 7'h7B;
  assign bad_opc = issue_instr_i.opc < 7'h70 || issue_instr_i.opc > 7'h7B;
  read_pulse_a: assert property (vrf_rd_o.en |=> !vrf_rd_o.en)
    else $error("read enable longer than one cycle");
  read_write_a: assert property (vrf_rd_o.en |-> ##3 vrf_wr_o.en)
    else $error("write not three cycles after read");
  write_gap_a: assert property (vrf_wr_o.en |=> !vrf_wr_o.en [*3])
    else $error("writes closer than four cycles");
  write_elem_a: assert property (vrf_wr_o.en |->
    vrf_wr_o.elem == vrf_rd_o.elem)
    else $error("written element differs from read element");
  elem_step_a: assert property (vrf_wr_o.en && vrf_wr_o.elem != 6'h00 |->
    vrf_wr_o.elem == $past(vrf_wr_o.elem, 4) + 6'h01)
    else $error("element order broken");
  busy_low_a: assert property (take && vector_length_count_i != 7'h00 |=>
    !issue_ready_o)
    else $error("ready stays high after take");
  zero_len_a: assert property (take && vector_length_count_i == 7'h00 |=>
    done_o && !vrf_wr_o.en)
    else $error("zero length not finished in one cycle");
  one_elem_a: assert property (take && vector_length_count_i == 7'h01 |->
    ##5 (done_o && $past(vrf_wr_o.en)))
    else $error("single element timing wrong");
  refuse_opc_a: assert property (issue_ready_o && issue_valid_i && bad_opc
    |=> issue_ready_o && !done_o)
    else $error("unknown opcode accepted");
endmodule
bind vfp_unit vfp_unit_chk u_chk(.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .issue_valid_i(issue_valid_i), .issue_instr_i(issue_instr_i),
  .vector_length_count_i(vector_length_count_i),
  .issue_ready_o(issue_ready_o), .done_o(done_o), .vrf_rd_o(vrf_rd_o),
  .vrf_wr_o(vrf_wr_o));
`default_nettype wire

// >>> vfp_vrf_model.sv
// vector register file model facing the unit
`default_nettype none
module vfp_vrf_model
  import vfp_pkg::*;
(
  input wire logic clk_i,
  input wire vfp_pkg::rd_req_type rd_i,
  input wire vfp_pkg::wr_req_type wr_i,
  output vfp_pkg::fp_word_type first_o,
  output vfp_pkg::fp_word_type second_o
);
  timeunit 1ns;
  timeprecision 1ps;
  fp_word_type mem [8][64];
  // register 7 holds an unnormalized half, all others one
  initial
  begin
    for (int r = 0; r < 8; r++)
      for (int e = 0; e < 64; e++)
        mem[r][e] = (r == 7) ? {1'b0, 15'h4001, 48'h400000000000} :
          {1'b0, 15'h4001, 48'h800000000000};
  end
  // data one cycle after the read, toggling garbage otherwise
  always @(posedge clk_i)
  begin
    first_o <= rd_i.en ? mem[rd_i.reg_a][rd_i.elem] : ~first_o;
    second_o <= rd_i.en ? mem[rd_i.reg_b][rd_i.elem] : ~second_o;
    if (wr_i.en)
      mem[wr_i.dst][wr_i.elem] <= wr_i.data;
  end
endmodule
`default_nettype wire
